/* File: verilog/pcn_pkg.sv */
// ****************************************************************************
// Register map and constants for the pin change notice / pull-up block
// ****************************************************************************
package pcn_pkg;

    // ************************************************************************
    // Widths
    // ************************************************************************
    localparam int          NUM_PINS      = 22;              // Implemented pins
    localparam int          DATA_W        = 32;              // APB data width
    localparam int          ADDR_W        = 8;               // Decoded address width
    localparam int          SYNC_STAGES   = 2;               // Pin synchroniser depth

    // ************************************************************************
    // Register offsets (byte addresses)
    // ************************************************************************
    localparam logic [7:0]  OFS_CNE       = 8'h00;           // change_notice_enable
    localparam logic [7:0]  OFS_CNE_CLR   = 8'h04;           // change_notice_enable_clear
    localparam logic [7:0]  OFS_CNE_SET   = 8'h08;           // change_notice_enable_set
    localparam logic [7:0]  OFS_CNE_INV   = 8'h0C;           // change_notice_enable_invert
    localparam logic [7:0]  OFS_PUE       = 8'h10;           // pullup_enable
    localparam logic [7:0]  OFS_PUE_CLR   = 8'h14;           // pullup_enable_clear
    localparam logic [7:0]  OFS_PUE_SET   = 8'h18;           // pullup_enable_set
    localparam logic [7:0]  OFS_PUE_INV   = 8'h1C;           // pullup_enable_invert
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h20;           // Change status, write one to clear
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h24;           // Change interrupt mask

    // ************************************************************************
    // Reset values and masks
    // ************************************************************************
    localparam logic [21:0] RST_CNE       = 22'h000000;      // Enable reset value
    localparam logic [21:0] RST_PUE       = 22'h000000;      // Pull-up reset value
    localparam logic [21:0] RST_STAT      = 22'h000000;      // Status reset value
    localparam logic [21:0] RST_MASK      = 22'h000000;      // Mask reset value
    localparam logic [31:0] ALIAS_RDATA   = 32'h00000000;    // Read value of aliases

    // ************************************************************************
    // Write operation kinds
    // ************************************************************************
    typedef enum logic [1:0]
    {
        PCN_OP_WRITE = 2'b00,
        PCN_OP_CLR   = 2'b01,
        PCN_OP_SET   = 2'b11,
        PCN_OP_INV   = 2'b10
    } pcn_op_e;

endpackage

/* File: verilog/pcn_alias_reg.sv */
`timescale 1ns/100ps
// ****************************************************************************
// One 22-bit register with plain, clear, set and invert write paths
// ****************************************************************************
module pcn_alias_reg
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Write request
    input  wire logic                 wr_en,
    input  wire pcn_pkg::pcn_op_e     wr_op,
    input  wire logic [31:0]          wr_data,
    // Stored value
    output logic [21:0]               value
);

    // Only implemented positions are ever touched
    logic [21:0] wr_bits;   // Low field of the written word
    logic [21:0] next_value;

    assign wr_bits = wr_data[21:0]; // [R1]

    // ************************************************************************
    // Next value per operation
    // ************************************************************************
    always_comb
    begin
        case (wr_op)
            // Plain write loads every implemented bit
            pcn_pkg::PCN_OP_WRITE: next_value = wr_bits;
            // Ones clear, zeros keep
            pcn_pkg::PCN_OP_CLR:   next_value = value & ~wr_bits; // [R4] [R12] [R7] [R8]
            // Ones set, zeros keep
            pcn_pkg::PCN_OP_SET:   next_value = value | wr_bits;  // [R5] [R13] [R7] [R8]
            // Ones toggle, zeros keep
            pcn_pkg::PCN_OP_INV:   next_value = value ^ wr_bits;  // [R6] [R14] [R7] [R8]
            default:               next_value = value;
        endcase
    end

    // ************************************************************************
    // Storage
    // ************************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value <= pcn_pkg::RST_CNE; // [R15]
        end
        else if (wr_en)
        begin
            value <= next_value;
        end
    end

endmodule

/* File: verilog/pcn_ctrl.sv */
`timescale 1ns/100ps
// Overview of operation
// [R1] Bits 31..22 reserved; write zero, read zero
// [R2] Input pin: enable bit turns detection on
// [R3] Output pin: enable bit ignored, no notice
// [R4] Enable clear alias clears written ones
// [R5] Enable set alias sets written ones
// [R6] Enable invert alias toggles written ones
// [R7] Written zeros leave target bits unchanged
// [R8] Aliases never touch reserved bit positions
// [R9] Alias reads undefined; read base register
// [R10] Input pin: pull-up bit drives weak pull-up
// [R11] Software keeps output pin pull-ups zero
// [R12] Pull-up clear alias clears written ones
// [R13] Pull-up set alias sets written ones
// [R14] Pull-up invert alias toggles written ones
// [R15] All enable and pull-up bits reset zero
module pcn_ctrl
(
    // APB slave
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Port pins
    input  wire logic [21:0]          pin_in,
    input  wire logic [21:0]          port_direction_bits,
    // Pin control outputs
    output logic [21:0]               pin_pullup_on,
    output logic [21:0]               pin_change_seen,
    // Interrupt
    output logic                      irq
);

    // ************************************************************************
    // Declarations
    // ************************************************************************
    logic [21:0]        change_notice_enable;  // Stored enable bits
    logic [21:0]        pullup_enable;         // Stored pull-up bits
    logic [21:0]        pin_sync1;             // First synchroniser stage
    logic [21:0]        pin_sync2;             // Second synchroniser stage
    logic [21:0]        pin_prev;              // Last sampled pin level
    logic [21:0]        change_event;          // Per-pin change this cycle
    logic [21:0]        irq_status;            // Sticky change flags
    logic [21:0]        irq_mask;              // Interrupt mask
    logic [21:0]        next_irq_status;       // Status next value
    logic               wr_access;             // Write access phase
    logic               rd_access;             // Read setup phase
    logic               addr_hit;              // Address is mapped
    logic               cne_wr;                // Enable register group hit
    logic               pue_wr;                // Pull-up register group hit
    pcn_pkg::pcn_op_e   wr_op;                 // Alias operation
    logic [31:0]        next_prdata;           // Read mux

    // ************************************************************************
    // APB decode
    // ************************************************************************
    // Zero wait states, so pready is always high
    assign pready    = 1'b1;
    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & ~penable & ~pwrite;

    // Address bits 3:2 pick the alias kind inside each group
    always_comb
    begin
        case (paddr[3:2])
            2'b00:   wr_op = pcn_pkg::PCN_OP_WRITE;
            2'b01:   wr_op = pcn_pkg::PCN_OP_CLR;
            2'b10:   wr_op = pcn_pkg::PCN_OP_SET;
            2'b11:   wr_op = pcn_pkg::PCN_OP_INV;
            default: wr_op = pcn_pkg::PCN_OP_WRITE;
        endcase
    end

    // Group selection on the upper offset bits
    assign cne_wr   = wr_access && (paddr[7:4] == pcn_pkg::OFS_CNE[7:4]) && (paddr[1:0] == 2'b00);
    assign pue_wr   = wr_access && (paddr[7:4] == pcn_pkg::OFS_PUE[7:4]) && (paddr[1:0] == 2'b00);

    // Mapped addresses
    always_comb
    begin
        case (paddr)
            pcn_pkg::OFS_CNE, pcn_pkg::OFS_CNE_CLR, pcn_pkg::OFS_CNE_SET,
            pcn_pkg::OFS_CNE_INV, pcn_pkg::OFS_PUE, pcn_pkg::OFS_PUE_CLR,
            pcn_pkg::OFS_PUE_SET, pcn_pkg::OFS_PUE_INV, pcn_pkg::OFS_IRQ_STAT,
            pcn_pkg::OFS_IRQ_MASK: addr_hit = 1'b1;
            default:               addr_hit = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error
    assign pslverr = psel & penable & ~addr_hit;

    // ************************************************************************
    // Enable and pull-up registers
    // ************************************************************************
    pcn_alias_reg u_cne_reg
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (cne_wr),
        .wr_op   (wr_op),
        .wr_data (pwdata),
        .value   (change_notice_enable)
    );

    pcn_alias_reg u_pue_reg
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (pue_wr),
        .wr_op   (wr_op),
        .wr_data (pwdata),
        .value   (pullup_enable)
    );

    // ************************************************************************
    // Pull-up drive: only on input pins
    // ************************************************************************
    // Direction bit one marks an input
    assign pin_pullup_on = pullup_enable & port_direction_bits; // [R10]

    // ************************************************************************
    // Pin synchroniser and change detect
    // ************************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync1 <= 22'h000000;
            pin_sync2 <= 22'h000000;
            pin_prev  <= 22'h000000;
        end
        else
        begin
            pin_sync1 <= pin_in;
            pin_sync2 <= pin_sync1;
            pin_prev  <= pin_sync2;
        end
    end

    // Per-pin gating by enable and direction
    genvar gi;
    generate
        for (gi = 0; gi < pcn_pkg::NUM_PINS; gi++)
        begin : g_pin
            // Output pins never raise a notice
            assign change_event[gi] = (pin_sync2[gi] ^ pin_prev[gi])
                                      & change_notice_enable[gi]    // [R2]
                                      & port_direction_bits[gi];    // [R3]
        end
    endgenerate

    // Registered copy of the per-pin change strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_change_seen <= 22'h000000;
        end
        else
        begin
            pin_change_seen <= change_event;
        end
    end

    // ************************************************************************
    // Interrupt status and mask
    // ************************************************************************
    // A new event wins over a write-one clear in the same cycle
    always_comb
    begin
        next_irq_status = irq_status;
        if (wr_access && (paddr == pcn_pkg::OFS_IRQ_STAT))
        begin
            next_irq_status = next_irq_status & ~pwdata[21:0];
        end
        next_irq_status = next_irq_status | change_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= pcn_pkg::RST_STAT;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask <= pcn_pkg::RST_MASK;
        end
        else if (wr_access && (paddr == pcn_pkg::OFS_IRQ_MASK))
        begin
            irq_mask <= pwdata[21:0];
        end
    end

    // Level interrupt while any unmasked flag stands
    assign irq = |(irq_status & irq_mask);

    // ************************************************************************
    // Read data
    // ************************************************************************
    // Upper ten bits always read zero; aliases read a fixed value
    always_comb
    begin
        case (paddr)
            pcn_pkg::OFS_CNE:      next_prdata = {10'h000, change_notice_enable}; // [R1]
            pcn_pkg::OFS_PUE:      next_prdata = {10'h000, pullup_enable};        // [R1]
            pcn_pkg::OFS_IRQ_STAT: next_prdata = {10'h000, irq_status};
            pcn_pkg::OFS_IRQ_MASK: next_prdata = {10'h000, irq_mask};
            default:               next_prdata = pcn_pkg::ALIAS_RDATA;
        endcase
    end

    // Read data captured in setup, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (rd_access)
        begin
            prdata <= next_prdata;
        end
    end

endmodule

/* File: sim/pcn_ctrl_chk.sv */
`timescale 1ns/100ps
// ****************************************************************************
// Port checker for the change notice block
// ****************************************************************************
module pcn_ctrl_chk
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and interrupt
    input wire logic [21:0] pin_in,
    input wire logic [21:0] port_direction_bits,
    input wire logic [21:0] pin_pullup_on,
    input wire logic [21:0] pin_change_seen,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr_acc = psel && penable && pwrite;   // Write taken this edge
    // ************************************************************************
    // Assertions
    // ************************************************************************
    reset_zero_a : assert property ($rose(presetn) |-> !irq && pin_pullup_on == 22'h0)
        else $error("outputs not zero after reset");
    rsvd_read_a : assert property (psel && penable && !pwrite |-> prdata[31:22] == 10'h000)
        else $error("reserved read bits not zero");
    pull_gate_a : assert property ((pin_pullup_on & ~port_direction_bits) == 22'h000000)
        else $error("pull-up on an output pin");
    pull_set_a : assert property (wr_acc && paddr == pcn_pkg::OFS_PUE_SET |=>
        (pin_pullup_on & $past(pwdata[21:0])) == ($past(pwdata[21:0]) & port_direction_bits))
        else $error("pull-up set alias missed bits");
    pull_clr_a : assert property (wr_acc && paddr == pcn_pkg::OFS_PUE_CLR |=>
        (pin_pullup_on & $past(pwdata[21:0])) == 22'h000000) else $error("pull-up clear missed");
    pull_inv_a : assert property (wr_acc && paddr == pcn_pkg::OFS_PUE_INV |=>
        (pin_pullup_on ^ $past(pin_pullup_on)) == ($past(pwdata[21:0]) & port_direction_bits))
        else $error("pull-up invert wrong bits");
    // Pulse seen at an edge reflects the pin step sampled three and four edges before
    change_cause_a : assert property
        ((pin_change_seen & ~($past(pin_in, 3) ^ $past(pin_in, 4))) == 22'h000000)
        else $error("change pulse without pin change");
    out_quiet_a : assert property
        ((pin_change_seen & ~$past(port_direction_bits)) == 22'h0)
        else $error("change pulse on an output pin");
    irq_cause_a : assert property ($rose(irq) |-> (|pin_change_seen) ||
        $past(wr_acc && paddr == pcn_pkg::OFS_IRQ_MASK)) else $error("interrupt without cause");
endmodule

bind pcn_ctrl pcn_ctrl_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .port_direction_bits(port_direction_bits),
    .pin_pullup_on(pin_pullup_on), .pin_change_seen(pin_change_seen), .irq(irq)
);

/* File: sim/tb.sv */
`timescale 1ns/100ps
// ****************************************************************************
// Self-checking bench for the change notice block
// ****************************************************************************
module tb;
    logic        pclk = 1'b0;                       // Bus clock
    logic        presetn = 1'b0;                    // Reset, active low
    logic        psel = 1'b0;                       // Select
    logic        penable = 1'b0;                    // Access phase
    logic        pwrite = 1'b0;                     // Direction
    logic [7:0]  paddr = 8'h00;                     // Byte address
    logic [31:0] pwdata = 32'h00000000;             // Write data
    logic [21:0] pin_in = 22'h000000;               // Pin levels
    logic [21:0] port_direction_bits = 22'h3FFFFF;  // All inputs at start
    logic [31:0] prdata;                            // Read data
    logic        pready;                            // Bus answer
    logic        pslverr;                           // Bus error
    logic [21:0] pin_pullup_on;                     // Pull-up outputs
    logic [21:0] pin_change_seen;                   // Change pulses
    logic        irq;                               // Interrupt
    logic [31:0] rd_val;                            // Last read data
    logic        err_seen;                          // Last error flag
    int          n_fail = 0;                        // Mismatches
    int          compares = 0;                      // Comparisons

    always #5 pclk = ~pclk;

    pcn_ctrl dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .port_direction_bits(port_direction_bits),
        .pin_pullup_on(pin_pullup_on), .pin_change_seen(pin_change_seen), .irq(irq)
    );

    // ************************************************************************
    // Shared tasks
    // ************************************************************************
    // Compare and count
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus transfer, held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_val = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write one place, read back another
    task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [7:0] b,
                input logic [31:0] exp);
        apb(1'b1, a, d);
        apb(1'b0, b, 32'h00000000);
        chk("register value", rd_val, exp);
    endtask

    // Final verdict
    task wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************************
    // Scenarios
    // ************************************************************************
    // Reset values of all registers
    task t_reset;
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h00000000);
            chk("reset value", rd_val, 32'h00000000);
            chk("slave error", {31'h0, err_seen}, 32'h00000000);
        end
    endtask

    // Alias writes on one register group
    task t_alias(input logic [7:0] b);
        // Base write keeps the reserved bits at zero
        wr_chk(b, 32'h003FFFFF, b, 32'h003FFFFF);
        wr_chk(b + 8'h04, 32'hFFC08001, b, 32'h003F7FFE);
        wr_chk(b + 8'h08, 32'hFFC00001, b, 32'h003F7FFF);
        wr_chk(b + 8'h0C, 32'hFFC08001, b, 32'h003FFFFE);
        apb(1'b0, b + 8'h0C, 32'h00000000);
        chk("alias read", rd_val, pcn_pkg::ALIAS_RDATA);
        wr_chk(b + 8'h04, 32'hFFFFFFFF, b, 32'h00000000);
        wr_chk(b + 8'h08, 32'h00008001, b, 32'h00008001);
    endtask

    // Pull-up cleared before direction change, unmapped address
    task t_pullup;
        @(negedge pclk);
        chk("pull-up", {10'h000, pin_pullup_on}, 32'h00008001);
        // Pull-up of pin 15 dropped before that pin turns to output
        apb(1'b1, pcn_pkg::OFS_PUE_CLR, 32'h00008000);
        @(posedge pclk);
        port_direction_bits <= 22'h000001;
        @(negedge pclk);
        chk("pull-up", {10'h000, pin_pullup_on}, 32'h00000001);
        apb(1'b0, 8'h30, 32'h00000000);
        chk("slave error", {31'h0, err_seen}, 32'h00000001);
        chk("unmapped read", rd_val, 32'h00000000);
    endtask

    // Change notice, interrupt mask and clear
    task t_change;
        logic [21:0] acc;
        wr_chk(pcn_pkg::OFS_CNE, 32'h00000003, pcn_pkg::OFS_CNE, 32'h00000003);
        apb(1'b1, pcn_pkg::OFS_IRQ_MASK, 32'h00000007);
        acc = 22'h000000;
        pin_in <= 22'h000007;
        repeat (8)
        begin
            @(posedge pclk);
            acc |= pin_change_seen;
        end
        chk("change pulse", {10'h000, acc}, 32'h00000001);
        chk("irq", {31'h0, irq}, 32'h00000001);
        wr_chk(pcn_pkg::OFS_IRQ_MASK, 32'h0, pcn_pkg::OFS_IRQ_STAT, 32'h00000001);
        chk("irq", {31'h0, irq}, 32'h00000000);
        wr_chk(pcn_pkg::OFS_IRQ_MASK, 32'h7, pcn_pkg::OFS_IRQ_STAT, 32'h00000001);
        chk("irq", {31'h0, irq}, 32'h00000001);
        wr_chk(pcn_pkg::OFS_IRQ_STAT, 32'h1, pcn_pkg::OFS_CNE_CLR, 32'h00000000);
        chk("irq", {31'h0, irq}, 32'h00000000);
        apb(1'b1, pcn_pkg::OFS_CNE_CLR, 32'h00000001);
        pin_in <= 22'h000000;
        repeat (8)
            @(posedge pclk);
        apb(1'b0, pcn_pkg::OFS_IRQ_STAT, 32'h00000000);
        chk("disabled pin", rd_val, 32'h00000000);
    endtask

    // ************************************************************************
    // Main sequence and watchdog
    // ************************************************************************
    initial
    begin
        repeat (20)
            @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_alias(pcn_pkg::OFS_CNE);
        t_alias(pcn_pkg::OFS_PUE);
        t_pullup();
        t_change();
        wrap_up();
    end

    initial
    begin
        repeat (5000)
            @(posedge pclk);
        n_fail++;
        wrap_up();
    end
endmodule
